// File: pkg/pdp_defs.svh
// constants of the process data bit packer
// Notes on behaviour
// - once the packing is configured, every channel of every module in a packed block gets one fixed bit position in that block's shared byte.
// - four two-channel input modules sharing a byte take bits 0-1, 2-3, 4-5 and 6-7 in order, with channel one on the lower bit.
// - in standard representation a module may join a packed block only when its length equals that of the block's first module.
// - in standard representation two same-direction modules are not packed together when a same-direction digital module of another length sits between them.
// - in standard representation a replacement module must keep the same length because the bit positions in the shared byte are fixed.
// - in typified representation following modules may have other lengths and their bits are placed contiguously after the previous module.
// - without packing every digital module gets a whole byte of its own, starting at bit 0.
// - the process data of one packed block never exceeds one byte; bits are appended until the byte is full.
`ifndef PDP_DEFS_SVH
`define PDP_DEFS_SVH

`define PDP_NSLOT 8
`define PDP_BYTE_W 8
`define PDP_FIFO_DEPTH 8
`define PDP_DIR_IN 1'b0
`define PDP_DIR_OUT 1'b1
`define PDP_LEN_WORD 4'h0
`define PDP_LEN_MAX 4'h8
`define PDP_FULL_BYTE 5'h08
`define PDP_ALL_ONES 8'hff
`define PDP_LAST_SLOT 3'h7

`endif

// File: pkg/pdp_pkg.sv
// types shared by the process data bit packer
`include "pdp_defs.svh"
package pdp_pkg;
	typedef struct packed {
		logic dir;
		logic join_prev;
		logic [3:0] len;
	} pdp_slot_cfg_t;

	typedef struct packed {
		logic word;
		logic refused;
		logic [2:0] byte_idx;
		logic [2:0] pos;
	} pdp_slot_map_t;

	typedef enum logic [3:0] {
		PDP_IDLE = 4'b0001,
		PDP_MAP = 4'b0010,
		PDP_READY = 4'b0100,
		PDP_EMIT = 4'b1000
	} pdp_state_t;
endpackage

// File: core/pdp_fifo.sv
// flop based fifo with valid/ready on both sides
`timescale 1ns/1ps
module pdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} pdp_fifo_state_t;

	pdp_fifo_state_t q;
	pdp_fifo_state_t next_q;
	logic push;
	logic pop;

	assign in_ready_o = (q.cnt != FULL);
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o = q.mem[q.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_q = q;
		if (push) begin
			next_q.mem[q.wr] = in_data_i;
			next_q.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			next_q.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
		end
		if (push && !pop) begin
			next_q.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			next_q.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	property p_fifo_no_overrun;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(q.cnt == FULL) && ce_i && !out_ready_i |=> (q.cnt == FULL) && !in_ready_o;
	endproperty
	a_fifo_no_overrun: assert property (p_fifo_no_overrun) else $error("fifo count moved while full");
endmodule

// File: core/pdp_packer.sv
// bit packer mapping 1-bit module channels into packed process data bytes
`timescale 1ns/1ps
`include "pdp_defs.svh"
module pdp_packer (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic cfg_load_i,
	input wire logic cfg_pack_en_i,
	input wire logic cfg_typified_i,
	input wire pdp_pkg::pdp_slot_cfg_t [`PDP_NSLOT-1:0] cfg_slots_i,
	input wire logic [`PDP_NSLOT-1:0][`PDP_BYTE_W-1:0] mod_in_bits_i,
	input wire logic cyc_start_i,
	output logic pd_in_valid_o,
	output logic [`PDP_BYTE_W-1:0] pd_in_data_o,
	input wire logic pd_in_ready_i,
	input wire logic pd_out_we_i,
	input wire logic [2:0] pd_out_idx_i,
	input wire logic [`PDP_BYTE_W-1:0] pd_out_data_i,
	output logic [`PDP_NSLOT-1:0][`PDP_BYTE_W-1:0] mod_out_bits_o,
	output logic map_ready_o,
	output logic [`PDP_NSLOT-1:0] cfg_refused_o,
	output logic [3:0] in_bytes_o,
	output logic [3:0] out_bytes_o
);
	typedef struct packed {
		pdp_pkg::pdp_state_t st;
		logic typ;
		logic pack;
		pdp_pkg::pdp_slot_cfg_t [`PDP_NSLOT-1:0] cfg;
		pdp_pkg::pdp_slot_map_t [`PDP_NSLOT-1:0] map;
		logic [2:0] slot;
		logic [1:0] open;
		logic [1:0][3:0] fill;
		logic [1:0][3:0] orig;
		logic [1:0][3:0] nbytes;
		logic [1:0][2:0] cur;
		logic [2:0] emit;
		logic [`PDP_NSLOT-1:0][`PDP_BYTE_W-1:0] outb;
	} pdp_pack_state_t;

	pdp_pack_state_t q;
	pdp_pack_state_t next_q;
	logic push_valid;
	logic [`PDP_BYTE_W-1:0] push_data;
	logic push_ready;

	// ==========================================================
	// helpers
	function automatic logic [`PDP_BYTE_W-1:0] pdp_mask(input logic [3:0] len);
		pdp_mask = `PDP_ALL_ONES >> (`PDP_LEN_MAX - len);
	endfunction

	function automatic logic pdp_digital(input pdp_pkg::pdp_slot_cfg_t c);
		pdp_digital = (c.len != `PDP_LEN_WORD) && (c.len <= `PDP_LEN_MAX);
	endfunction

	// collects every input module mapped to one byte at its own bit position
	function automatic logic [`PDP_BYTE_W-1:0] pdp_gather(
		input pdp_pkg::pdp_slot_cfg_t [`PDP_NSLOT-1:0] cfg,
		input pdp_pkg::pdp_slot_map_t [`PDP_NSLOT-1:0] map,
		input logic [`PDP_NSLOT-1:0][`PDP_BYTE_W-1:0] bits,
		input logic [2:0] idx);
		logic [`PDP_BYTE_W-1:0] acc;
		acc = '0;
		for (int s = 0; s < `PDP_NSLOT; s++) begin
			if (!map[s].word && cfg[s].dir == `PDP_DIR_IN && map[s].byte_idx == idx) begin
				acc = acc | ((bits[s] & pdp_mask(cfg[s].len)) << map[s].pos);
			end
		end
		pdp_gather = acc;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic d;
		logic fits;
		logic join_ok;
		pdp_pkg::pdp_slot_cfg_t c;
		d = 1'b0;
		fits = 1'b0;
		join_ok = 1'b0;
		c = q.cfg[q.slot];
		next_q = q;
		push_valid = 1'b0;
		push_data = pdp_gather(q.cfg, q.map, mod_in_bits_i, q.emit);
		unique case (q.st)
			pdp_pkg::PDP_IDLE, pdp_pkg::PDP_READY: begin
				if (cfg_load_i) begin
					next_q.st = pdp_pkg::PDP_MAP;
					next_q.typ = cfg_typified_i;
					next_q.pack = cfg_pack_en_i;
					next_q.cfg = cfg_slots_i;
					next_q.map = '0;
					next_q.slot = '0;
					next_q.open = '0;
					next_q.fill = '0;
					next_q.orig = '0;
					next_q.nbytes = '0;
					next_q.cur = '0;
				end else if (q.st == pdp_pkg::PDP_READY && cyc_start_i
						&& q.nbytes[`PDP_DIR_IN] != 4'h0) begin
					next_q.st = pdp_pkg::PDP_EMIT;
					next_q.emit = '0;
				end
			end
			pdp_pkg::PDP_MAP: begin
				d = c.dir;
				if (!pdp_digital(c)) begin
					// word wide modules stay outside the packed byte space
					next_q.map[q.slot].word = 1'b1;
				end else begin
					fits = ({1'b0, q.fill[d]} + {1'b0, c.len}) <= `PDP_FULL_BYTE;
					// the equal length check also rejects a join across a different length
					// digital module, since that module opened the current block
					join_ok = q.pack && c.join_prev && q.open[d] && fits
						&& (q.typ || c.len == q.orig[d]);
					next_q.map[q.slot].refused = q.pack && c.join_prev && q.open[d] && !join_ok;
					if (join_ok) begin
						next_q.map[q.slot].byte_idx = q.cur[d];
						next_q.map[q.slot].pos = q.fill[d][2:0];
						next_q.fill[d] = q.fill[d] + c.len;
					end else begin
						next_q.map[q.slot].byte_idx = q.nbytes[d][2:0];
						next_q.map[q.slot].pos = '0;
						next_q.cur[d] = q.nbytes[d][2:0];
						next_q.nbytes[d] = q.nbytes[d] + 4'h1;
						next_q.fill[d] = c.len;
						next_q.orig[d] = c.len;
						next_q.open[d] = q.pack;
					end
				end
				if (q.slot == `PDP_LAST_SLOT) begin
					next_q.st = pdp_pkg::PDP_READY;
				end else begin
					next_q.slot = q.slot + 3'h1;
				end
			end
			pdp_pkg::PDP_EMIT: begin
				push_valid = 1'b1;
				if (push_ready) begin
					next_q.emit = q.emit + 3'h1;
					if ({1'b0, q.emit} == q.nbytes[`PDP_DIR_IN] - 4'h1) begin
						next_q.st = pdp_pkg::PDP_READY;
					end
				end
			end
		endcase
		// output bytes are scattered only while the map is valid and frozen
		if ((q.st == pdp_pkg::PDP_READY || q.st == pdp_pkg::PDP_EMIT) && pd_out_we_i) begin
			for (int s = 0; s < `PDP_NSLOT; s++) begin
				if (!q.map[s].word && q.cfg[s].dir == `PDP_DIR_OUT
						&& q.map[s].byte_idx == pd_out_idx_i) begin
					next_q.outb[s] = (pd_out_data_i >> q.map[s].pos) & pdp_mask(q.cfg[s].len);
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.st <= pdp_pkg::PDP_IDLE;
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outward buffering
	pdp_fifo #(
		.WIDTH(`PDP_BYTE_W),
		.DEPTH(`PDP_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.in_valid_i(push_valid),
		.in_data_i(push_data),
		.in_ready_o(push_ready),
		.out_valid_o(pd_in_valid_o),
		.out_data_o(pd_in_data_o),
		.out_ready_i(pd_in_ready_i)
	);

	assign mod_out_bits_o = q.outb;
	assign map_ready_o = (q.st == pdp_pkg::PDP_READY) || (q.st == pdp_pkg::PDP_EMIT);
	assign in_bytes_o = q.nbytes[`PDP_DIR_IN];
	assign out_bytes_o = q.nbytes[`PDP_DIR_OUT];
	always_comb begin
		for (int s = 0; s < `PDP_NSLOT; s++) begin
			cfg_refused_o[s] = q.map[s].refused;
		end
	end

	// ==========================================================
	// checks
	function automatic logic chk_fit(input pdp_pack_state_t x);
		chk_fit = 1'b1;
		for (int s = 0; s < `PDP_NSLOT; s++) begin
			if (!x.map[s].word && ({2'b00, x.map[s].pos} + {1'b0, x.cfg[s].len}) > `PDP_FULL_BYTE) begin
				chk_fit = 1'b0;
			end
		end
	endfunction

	function automatic logic chk_unpacked(input pdp_pack_state_t x);
		chk_unpacked = 1'b1;
		for (int s = 0; s < `PDP_NSLOT; s++) begin
			if (x.map[s].pos != '0 || x.map[s].refused) begin
				chk_unpacked = 1'b0;
			end
		end
	endfunction

	property p_load_maps;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		ce_i && cfg_load_i && q.st == pdp_pkg::PDP_READY |=> q.st == pdp_pkg::PDP_MAP;
	endproperty
	a_load_maps: assert property (p_load_maps) else $error("load did not start mapping");

	property p_map_bounded;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(q.st == pdp_pkg::PDP_MAP) && ce_i |-> ##[1:64] q.st == pdp_pkg::PDP_READY;
	endproperty
	a_map_bounded: assert property (p_map_bounded) else $error("mapping did not finish");

	property p_frozen;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o && !cfg_load_i |=> $stable(q.map) && $stable(q.cfg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("bit map changed without reload");

	property p_fit;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o |-> chk_fit(q);
	endproperty
	a_fit: assert property (p_fit) else $error("packed block exceeds one byte");

	property p_unpacked;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o && !q.pack |-> chk_unpacked(q);
	endproperty
	a_unpacked: assert property (p_unpacked) else $error("unpacked module not at bit 0");

	property p_std_equal;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o && !q.typ && q.map[1].pos != '0 |->
			q.cfg[1].len == q.cfg[0].len && q.map[1].pos == q.cfg[0].len[2:0];
	endproperty
	a_std_equal: assert property (p_std_equal) else $error("standard block with unequal lengths");

	property p_typ_contig;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o && q.map[1].pos != '0 |-> q.map[1].pos == q.cfg[0].len[2:0]
			&& q.map[1].byte_idx == q.map[0].byte_idx;
	endproperty
	a_typ_contig: assert property (p_typ_contig) else $error("joined bits not contiguous");

	property p_scatter;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		ce_i && map_ready_o && pd_out_we_i && !q.map[0].word && q.cfg[0].dir == `PDP_DIR_OUT
			&& q.map[0].byte_idx == pd_out_idx_i |=>
			mod_out_bits_o[0] == (($past(pd_out_data_i) >> q.map[0].pos) & pdp_mask(q.cfg[0].len));
	endproperty
	a_scatter: assert property (p_scatter) else $error("output bits not taken from their position");

	property p_refused_new_byte;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		map_ready_o && q.map[1].refused |-> q.map[1].pos == '0
			&& q.map[1].byte_idx != q.map[0].byte_idx;
	endproperty
	a_refused_new_byte: assert property (p_refused_new_byte) else $error("refused module was packed");
endmodule

// File: verification/pdp_master_model.sv
// fieldbus master model: drains packed input bytes and writes output bytes
`timescale 1ns/1ps
module pdp_master_model (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic stall_i,
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	output logic in_ready_o,
	output logic out_we_o,
	output logic [2:0] out_idx_o,
	output logic [7:0] out_data_o
);
	logic [7:0] got[$];

	initial begin
		in_ready_o = 1'b0;
		out_we_o = 1'b0;
		out_idx_o = 3'h0;
		out_data_o = 8'h00;
	end

	// ready only moves just after an edge, so a byte is never half taken
	always @(posedge sys_clk_i) begin
		if (arst_n_i && in_valid_i && in_ready_o) begin
			got.push_back(in_data_i);
		end
		in_ready_o <= #1 !stall_i && arst_n_i;
	end

	task automatic write_byte(input logic [2:0] idx, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		out_we_o = 1'b1;
		out_idx_o = idx;
		out_data_o = d;
		@(posedge sys_clk_i);
		#1;
		// released lines show the inverse, never a stale copy
		out_we_o = 1'b0;
		out_idx_o = ~idx;
		out_data_o = ~d;
	endtask
endmodule

// File: verification/tb_top.sv
// self-checking testbench of the process data bit packer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
	n_tests++; \
	if ((gt) !== (ex)) begin \
		err_count++; \
		$display("wrong value %s expected %h seen %h", nm, ex, gt); \
	end \
end
module tb_top;
	logic clk, arst_n, ce, cfg_load, pack_en, typ, cyc_start, stall;
	logic pd_in_valid, pd_in_ready, we, map_ready;
	logic [7:0] pd_in_data, od, refused;
	logic [2:0] idx;
	logic [3:0] in_bytes, out_bytes;
	pdp_pkg::pdp_slot_cfg_t [7:0] slots;
	logic [7:0][7:0] mib, mob;
	int err_count = 0;
	int n_tests = 0;

	pdp_packer dut_u (.sys_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .cfg_load_i(cfg_load),
		.cfg_pack_en_i(pack_en), .cfg_typified_i(typ), .cfg_slots_i(slots),
		.mod_in_bits_i(mib), .cyc_start_i(cyc_start), .pd_in_valid_o(pd_in_valid),
		.pd_in_data_o(pd_in_data), .pd_in_ready_i(pd_in_ready), .pd_out_we_i(we),
		.pd_out_idx_i(idx), .pd_out_data_i(od), .mod_out_bits_o(mob),
		.map_ready_o(map_ready), .cfg_refused_o(refused), .in_bytes_o(in_bytes),
		.out_bytes_o(out_bytes));
	pdp_master_model m_u (.sys_clk_i(clk), .arst_n_i(arst_n), .stall_i(stall),
		.in_valid_i(pd_in_valid), .in_data_i(pd_in_data), .in_ready_o(pd_in_ready),
		.out_we_o(we), .out_idx_o(idx), .out_data_o(od));

	// ==========================================
	// helpers
	function automatic pdp_pkg::pdp_slot_cfg_t sc(input logic d, input logic j,
		input logic [3:0] l);
		sc = '{dir: d, join_prev: j, len: l};
	endfunction

	task automatic load(input logic pk, input logic ty, input pdp_pkg::pdp_slot_cfg_t [7:0] c,
		input logic [3:0] ni, input logic [3:0] no, input logic [7:0] rf);
		pack_en = pk;
		typ = ty;
		slots = c;
		cfg_load = 1'b1;
		@(posedge clk);
		#1;
		cfg_load = 1'b0;
		`CHK("map ready in map", 1'b0, map_ready)
		for (int i = 0; i < 20 && map_ready !== 1'b1; i++) @(posedge clk);
		#1;
		`CHK("map ready", 1'b1, map_ready)
		`CHK("in bytes", ni, in_bytes)
		`CHK("out bytes", no, out_bytes)
		`CHK("refused", rf, refused)
	endtask

	// hold keeps the master stalled so the whole image piles up in the fifo
	task automatic image(input logic [7:0][7:0] bits, input int n, input logic [7:0][7:0] ex,
		input logic hold);
		m_u.got.delete();
		mib = bits;
		stall = hold;
		cyc_start = 1'b1;
		@(posedge clk);
		#1;
		cyc_start = 1'b0;
		if (hold) begin
			repeat (20) @(posedge clk);
			#1;
			`CHK("valid while stalled", 1'b1, pd_in_valid)
			`CHK("bytes while stalled", 0, m_u.got.size())
			stall = 1'b0;
		end
		for (int i = 0; i < 80 && m_u.got.size() < n; i++) @(posedge clk);
		repeat (3) @(posedge clk);
		#1;
		`CHK("byte count", n, m_u.got.size())
		for (int k = 0; k < n; k++) `CHK("in byte", ex[k], m_u.got[k])
	endtask

	// ==========================================
	// scenarios
	task automatic t_std();
		pdp_pkg::pdp_slot_cfg_t [7:0] c;
		c = {sc(1'b0, 1'b0, 4'h0), sc(1'b0, 1'b1, 4'h2), sc(1'b1, 1'b1, 4'h2),
			sc(1'b1, 1'b0, 4'h2), sc(1'b0, 1'b1, 4'h2), sc(1'b0, 1'b1, 4'h2),
			sc(1'b0, 1'b1, 4'h4), sc(1'b0, 1'b0, 4'h2)};
		load(1'b1, 1'b0, c, 4'h3, 4'h1, 8'h06);
		image({8'h00, 8'hf7, 16'h0, 8'hfe, 8'hfd, 8'hf9, 8'hfe}, 3,
			{40'h0, 8'h39, 8'h09, 8'h02}, 1'b0);
		$display("test standard done");
		load(1'b1, 1'b1, c, 4'h2, 4'h1, 8'h08);
		image({8'h00, 8'hf7, 16'h0, 8'hfe, 8'hfd, 8'hf9, 8'hfe}, 2,
			{48'h0, 8'h0e, 8'h66}, 1'b0);
		$display("test typified done");
	endtask

	task automatic t_unpacked();
		pdp_pkg::pdp_slot_cfg_t [7:0] c;
		logic [7:0][7:0] ex;
		for (int s = 0; s < 8; s++) begin
			c[s] = sc(1'b0, 1'b1, 4'(s + 1));
			ex[s] = 8'((9'h001 << (s + 1)) - 9'h001);
		end
		load(1'b0, 1'b0, c, 4'h8, 4'h0, 8'h00);
		image({8{8'hff}}, 8, ex, 1'b1);
		$display("test unpacked done");
	endtask

	task automatic t_four();
		pdp_pkg::pdp_slot_cfg_t [7:0] c;
		for (int s = 0; s < 8; s++) c[s] = sc(s > 3, (s % 4) != 0, 4'h2);
		load(1'b1, 1'b0, c, 4'h1, 4'h1, 8'h00);
		image({32'h0, 8'hfd, 8'hff, 8'hfe, 8'hfd}, 1, {56'h0, 8'h79}, 1'b0);
		m_u.write_byte(3'h0, 8'hb4);
		@(posedge clk);
		#1;
		`CHK("out slot 4", 8'h00, mob[4])
		`CHK("out slot 5", 8'h01, mob[5])
		`CHK("out slot 6", 8'h03, mob[6])
		`CHK("out slot 7", 8'h02, mob[7])
		load(1'b1, 1'b0, c, 4'h1, 4'h1, 8'h00);
		`CHK("out kept", 8'h03, mob[6])
		$display("test four modules done");
	endtask

	// ce low must hold the mapper still; a word slot between joined outputs takes no bits
	task automatic t_out_ce();
		pdp_pkg::pdp_slot_cfg_t [7:0] c;
		c = '0;
		c[0] = sc(1'b1, 1'b0, 4'h2);
		c[1] = sc(1'b1, 1'b1, 4'h4);
		c[2] = sc(1'b1, 1'b1, 4'h9);
		c[3] = sc(1'b1, 1'b1, 4'h2);
		pack_en = 1'b1;
		typ = 1'b1;
		slots = c;
		cfg_load = 1'b1;
		@(posedge clk);
		#1;
		cfg_load = 1'b0;
		ce = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		`CHK("map ready frozen", 1'b0, map_ready)
		ce = 1'b1;
		repeat (7) @(posedge clk);
		#1;
		`CHK("map ready early", 1'b0, map_ready)
		@(posedge clk);
		#1;
		`CHK("map ready late", 1'b1, map_ready)
		`CHK("in bytes none", 4'h0, in_bytes)
		`CHK("out bytes one", 4'h1, out_bytes)
		`CHK("refused none", 8'h00, refused)
		m_u.write_byte(3'h0, 8'h9b);
		@(posedge clk);
		#1;
		`CHK("out slot 0", 8'h03, mob[0])
		`CHK("out slot 1", 8'h06, mob[1])
		`CHK("out word slot", 8'h00, mob[2])
		`CHK("out slot 3", 8'h02, mob[3])
		$display("test clock enable done");
	endtask

	// a reset in mid-run clears map and outputs, and a load right after release is taken
	task automatic t_reset();
		pdp_pkg::pdp_slot_cfg_t [7:0] c;
		c = '0;
		c[0] = sc(1'b1, 1'b1, 4'h2);
		c[1] = sc(1'b1, 1'b1, 4'h4);
		arst_n = 1'b0;
		@(posedge clk);
		#1;
		`CHK("map ready in reset", 1'b0, map_ready)
		`CHK("out bytes in reset", 4'h0, out_bytes)
		`CHK("out slot in reset", 8'h00, mob[0])
		`CHK("valid in reset", 1'b0, pd_in_valid)
		arst_n = 1'b1;
		load(1'b0, 1'b0, c, 4'h0, 4'h2, 8'h00);
		$display("test reset done");
	endtask

	// ==========================================
	// run control
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the whole run needs some 150 cycles
	initial begin
		#300000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		arst_n = 1'b0;
		cfg_load = 1'b0;
		pack_en = 1'b0;
		typ = 1'b0;
		cyc_start = 1'b0;
		stall = 1'b0;
		slots = '0;
		mib = '0;
		ce = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_std();
		t_unpacked();
		t_four();
		t_out_ce();
		t_reset();
		tally_and_finish();
	end
endmodule
